// file: design/bitop_pkg.sv
// Constants, opcodes and carrier types for the executor.
package bitop_pkg;

  // ****************************************************************
  // Widths and register file layout
  // ****************************************************************
  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 16;
  localparam int NUM_REGS   = 32;
  localparam int REG_IDX_W  = 5;
  localparam int BUS_ADDR_W = 6;
  localparam int DISP_W     = 6;
  localparam int BIT_IDX_W  = 3;

  localparam logic [REG_IDX_W-1:0] PTR_X_LO = 5'h1a;
  localparam logic [REG_IDX_W-1:0] PTR_Y_LO = 5'h1c;
  localparam logic [REG_IDX_W-1:0] PTR_Z_LO = 5'h1e;

  // ****************************************************************
  // Register port map
  // ****************************************************************
  localparam logic [BUS_ADDR_W-1:0] REGFILE_LAST  = 6'h1f;
  localparam logic [BUS_ADDR_W-1:0] FLAG_REG_ADDR = 6'h3f;
  localparam logic [DATA_W-1:0]     FLAG_RESET    = 8'h00;
  localparam logic [DATA_W-1:0]     GPR_RESET     = 8'h00;

  // ****************************************************************
  // Flag register bit positions
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ****************************************************************
  // Operations
  // ****************************************************************
  typedef enum logic [5:0] {
    op_none              = 6'h00,
    op_rotate_right_carry = 6'h01,
    op_arith_shift_right = 6'h02,
    op_nibble_swap       = 6'h03,
    op_indexed_flag_set  = 6'h04,
    op_indexed_flag_clear = 6'h05,
    op_reg_bit_to_t_flag = 6'h06,
    op_t_flag_to_reg_bit = 6'h07,
    op_carry_set_op      = 6'h08,
    op_carry_clear_op    = 6'h09,
    op_negative_set_op   = 6'h0a,
    op_negative_clear_op = 6'h0b,
    op_zero_set_op       = 6'h0c,
    op_zero_clear_op     = 6'h0d,
    op_irq_global_on     = 6'h0e,
    op_irq_global_off    = 6'h0f,
    op_sign_set_op       = 6'h10,
    op_sign_clear_op     = 6'h11,
    op_overflow_set_op   = 6'h12,
    op_overflow_clear_op = 6'h13,
    op_tflag_set_op      = 6'h14,
    op_tflag_clear_op    = 6'h15,
    op_halfcarry_set_op  = 6'h16,
    op_halfcarry_clear_op = 6'h17,
    op_reg_copy          = 6'h18,
    op_reg_pair_copy     = 6'h19,
    op_immediate_load    = 6'h1a,
    op_indirect_load     = 6'h1b,
    op_displaced_load    = 6'h1c,
    op_direct_load       = 6'h1d,
    op_indirect_write    = 6'h1e
  } op_t;

  typedef enum logic [1:0] {
    ptr_x = 2'h0,
    ptr_y = 2'h1,
    ptr_z = 2'h2
  } ptr_sel_t;

  typedef enum logic [1:0] {
    am_plain    = 2'h0,
    am_post_inc = 2'h1,
    am_pre_dec  = 2'h2,
    am_disp     = 2'h3
  } amode_t;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_mem  = 2'b10
  } state_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    op_t                  op;
    logic [REG_IDX_W-1:0] rd;
    logic [REG_IDX_W-1:0] rr;
    logic [BIT_IDX_W-1:0] bit_sel;
    logic [DATA_W-1:0]    imm;
    ptr_sel_t             ptr;
    amode_t               amode;
    logic [DISP_W-1:0]    disp;
    logic [ADDR_W-1:0]    addr;
  } cmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } mem_req_t;

endpackage

// file: design/bitop_shift_unit.sv
// Right shift, rotate and nibble exchange with their flag results.
`timescale 1ns/1ps
module bitop_shift_unit
  import bitop_pkg::*;
(
  input  wire bitop_pkg::op_t         i_op,
  input  wire logic [DATA_W-1:0]      i_value,
  input  wire logic                   i_carry,
  output logic      [DATA_W-1:0]      o_result,
  output logic                        o_c,
  output logic                        o_z,
  output logic                        o_n,
  output logic                        o_v
);
  import bitop_pkg::*;

  always_comb begin
    case (i_op)
      op_rotate_right_carry: o_result = {i_carry, i_value[DATA_W-1:1]};            // [RQ1]
      op_arith_shift_right:  o_result = {i_value[DATA_W-1], i_value[DATA_W-1:1]};  // [RQ2]
      op_nibble_swap:        o_result = {i_value[3:0], i_value[7:4]};              // [RQ12]
      default:               o_result = i_value;
    endcase
  end

  // Carry takes the bit shifted out.
  assign o_c = i_value[0];              // [RQ1] [RQ2]
  assign o_n = o_result[DATA_W-1];
  assign o_z = (o_result == '0);
  assign o_v = o_n ^ o_c;

endmodule

// file: design/bitop_ptr_unit.sv
// Address generation and pointer update for data memory accesses.
`timescale 1ns/1ps
module bitop_ptr_unit
  import bitop_pkg::*;
(
  input  wire logic [ADDR_W-1:0]      i_ptr,
  input  wire bitop_pkg::amode_t      i_amode,
  input  wire logic [DISP_W-1:0]      i_disp,
  input  wire logic                   i_direct,
  input  wire logic [ADDR_W-1:0]      i_direct_addr,
  output logic      [ADDR_W-1:0]      o_addr,
  output logic      [ADDR_W-1:0]      o_ptr_next,
  output logic                        o_ptr_upd
);
  import bitop_pkg::*;

  logic [ADDR_W-1:0] inc;
  logic [ADDR_W-1:0] dec;

  assign inc = i_ptr + ADDR_W'(1);
  assign dec = i_ptr - ADDR_W'(1);

  always_comb begin
    o_ptr_next = i_ptr;
    o_ptr_upd  = 1'b0;
    if (i_direct) begin
      o_addr = i_direct_addr;                       // [RQ9]
    end else begin
      case (i_amode)
        am_post_inc: begin
          o_addr     = i_ptr;                       // [RQ7] [RQ10]
          o_ptr_next = inc;
          o_ptr_upd  = 1'b1;
        end
        am_pre_dec: begin
          o_addr     = dec;                         // [RQ8] [RQ11]
          o_ptr_next = dec;
          o_ptr_upd  = 1'b1;
        end
        am_disp:  o_addr = i_ptr + {{(ADDR_W-DISP_W){1'b0}}, i_disp};  // [RQ6]
        default:  o_addr = i_ptr;                   // [RQ13]
      endcase
    end
  end

endmodule

// file: design/bitop_load_store_exec.sv
// Executor for shifts, flag ops, moves, loads and stores.
`timescale 1ns/1ps
// Summary of operation
// RQ1 - Rotate right through carry puts carry in bit 7, shifts down, old bit 0 to carry, sets Z C N V, one cycle.
// RQ2 - Arithmetic shift right keeps bit 7, shifts bits 7..1 down, sets Z C N V, one cycle.
// RQ3 - Register bit to T copies the chosen source bit into T only, in one cycle.
// RQ4 - T to register bit writes T into the chosen destination bit, no flag change, one cycle.
// RQ5 - Each dedicated flag set or clear op forces only its own flag in one cycle.
// RQ6 - Displaced load reads memory at Y or Z plus unsigned displacement, pointer and flags kept, two cycles.
// RQ7 - Post-increment load reads at the pointer, then adds one to it, no flags, two cycles.
// RQ8 - Pre-decrement load subtracts one from the pointer and reads at the new value, two cycles.
// RQ9 - Direct load reads the absolute address into the destination, two cycles, no flags.
// RQ10 - Post-increment store writes the source at the pointer then increments it, two cycles.
// RQ11 - Pre-decrement store decrements the pointer then writes at the new address, two cycles.
// RQ12 - Register copy, pair copy, immediate load, nibble swap and indexed flag ops take one cycle.
// RQ13 - Plain indirect loads and stores use the pointer unchanged, two cycles, no flags.
module bitop_load_store_exec
  import bitop_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_cmd_valid,
  input  wire bitop_pkg::cmd_t           i_cmd,
  output logic                           o_ready,
  output logic                           o_done,
  output bitop_pkg::mem_req_t            o_mem,
  input  wire logic [DATA_W-1:0]         i_mem_rdata,
  output logic      [DATA_W-1:0]         o_flags,
  input  wire logic [BUS_ADDR_W-1:0]     i_reg_addr,
  input  wire logic [DATA_W-1:0]         i_reg_wdata,
  input  wire logic                      i_reg_we,
  input  wire logic                      i_reg_re,
  output logic      [DATA_W-1:0]         o_reg_rdata
);
  import bitop_pkg::*;

  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [DATA_W-1:0]    gpr_r [NUM_REGS];
  logic [DATA_W-1:0]    flags_r;
  state_t               state_r;
  logic [REG_IDX_W-1:0] load_rd_r;
  logic                 load_pend_r;
  logic                 done_r;
  mem_req_t             mem_r;
  logic [DATA_W-1:0]    reg_rdata_r;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic                 take;
  logic                 is_mem_op;
  logic                 is_load;
  logic                 is_direct;
  logic [REG_IDX_W-1:0] ptr_lo;
  logic [ADDR_W-1:0]    ptr_val;
  logic [ADDR_W-1:0]    mem_addr;
  logic [ADDR_W-1:0]    ptr_next;
  logic                 ptr_upd;
  logic [DATA_W-1:0]    rd_val;
  logic [DATA_W-1:0]    rr_val;
  logic [DATA_W-1:0]    shift_res;
  logic                 sh_c;
  logic                 sh_z;
  logic                 sh_n;
  logic                 sh_v;
  logic                 fix_flag;
  logic [2:0]           fix_idx;
  logic                 fix_val;
  amode_t               eff_amode;

  assign take      = i_cmd_valid && (state_r == st_idle);
  assign is_load   = (i_cmd.op == op_indirect_load) || (i_cmd.op == op_displaced_load)
                     || (i_cmd.op == op_direct_load);
  assign is_mem_op = is_load || (i_cmd.op == op_indirect_write);
  assign is_direct = (i_cmd.op == op_direct_load);
  assign rd_val    = gpr_r[i_cmd.rd];
  assign rr_val    = gpr_r[i_cmd.rr];

  always_comb begin
    case (i_cmd.ptr)
      ptr_y:   ptr_lo = PTR_Y_LO;
      ptr_z:   ptr_lo = PTR_Z_LO;
      default: ptr_lo = PTR_X_LO;
    endcase
  end

  assign ptr_val = {gpr_r[ptr_lo + REG_IDX_W'(1)], gpr_r[ptr_lo]};

  // Only the displaced load adds the displacement.
  always_comb begin
    if (i_cmd.op == op_displaced_load) begin
      eff_amode = am_disp;                                          // [RQ6]
    end else if (i_cmd.amode == am_disp) begin
      eff_amode = am_plain;
    end else begin
      eff_amode = i_cmd.amode;
    end
  end

  bitop_ptr_unit u_ptr (
    .i_ptr         (ptr_val),
    .i_amode       (eff_amode),
    .i_disp        (i_cmd.disp),
    .i_direct      (is_direct),
    .i_direct_addr (i_cmd.addr),
    .o_addr        (mem_addr),
    .o_ptr_next    (ptr_next),
    .o_ptr_upd     (ptr_upd)
  );

  bitop_shift_unit u_shift (
    .i_op     (i_cmd.op),
    .i_value  (rd_val),
    .i_carry  (flags_r[FLAG_C]),
    .o_result (shift_res),
    .o_c      (sh_c),
    .o_z      (sh_z),
    .o_n      (sh_n),
    .o_v      (sh_v)
  );

  // Each flag force op picks one flag and its value.
  always_comb begin
    fix_flag = 1'b1;
    fix_val  = 1'b0;
    fix_idx  = 3'(FLAG_C);
    case (i_cmd.op)
      op_carry_set_op:       begin fix_idx = 3'(FLAG_C); fix_val = 1'b1; end
      op_carry_clear_op:     fix_idx = 3'(FLAG_C);
      op_negative_set_op:    begin fix_idx = 3'(FLAG_N); fix_val = 1'b1; end
      op_negative_clear_op:  fix_idx = 3'(FLAG_N);
      op_zero_set_op:        begin fix_idx = 3'(FLAG_Z); fix_val = 1'b1; end
      op_zero_clear_op:      fix_idx = 3'(FLAG_Z);
      op_irq_global_on:      begin fix_idx = 3'(FLAG_I); fix_val = 1'b1; end
      op_irq_global_off:     fix_idx = 3'(FLAG_I);
      op_sign_set_op:        begin fix_idx = 3'(FLAG_S); fix_val = 1'b1; end
      op_sign_clear_op:      fix_idx = 3'(FLAG_S);
      op_overflow_set_op:    begin fix_idx = 3'(FLAG_V); fix_val = 1'b1; end
      op_overflow_clear_op:  fix_idx = 3'(FLAG_V);
      op_tflag_set_op:       begin fix_idx = 3'(FLAG_T); fix_val = 1'b1; end
      op_tflag_clear_op:     fix_idx = 3'(FLAG_T);
      op_halfcarry_set_op:   begin fix_idx = 3'(FLAG_H); fix_val = 1'b1; end
      op_halfcarry_clear_op: fix_idx = 3'(FLAG_H);
      op_indexed_flag_set:   begin fix_idx = i_cmd.bit_sel; fix_val = 1'b1; end
      op_indexed_flag_clear: fix_idx = i_cmd.bit_sel;
      default:               fix_flag = 1'b0;
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Memory ops block one cycle so each takes two.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= st_idle;
    end else begin
      case (state_r)
        st_idle: begin
          if (take && is_mem_op) begin
            state_r <= st_mem;                         // [RQ6] [RQ7] [RQ8] [RQ9] [RQ13]
          end
        end
        st_mem:  state_r <= st_idle;
        default: state_r <= st_idle;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      load_pend_r <= 1'b0;
      load_rd_r   <= '0;
    end else begin
      load_pend_r <= take && is_load;
      if (take && is_load) begin
        load_rd_r <= i_cmd.rd;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (take && !is_mem_op) || (state_r == st_mem);
    end
  end

  // ****************************************************************
  // Data memory request
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mem_r <= '0;
    end else begin
      mem_r.we <= 1'b0;
      mem_r.re <= 1'b0;
      if (take && is_mem_op) begin
        mem_r.addr <= mem_addr;                        // [RQ6] [RQ8] [RQ9] [RQ11]
        mem_r.re   <= is_load;
        mem_r.we   <= !is_load;                        // [RQ10] [RQ11] [RQ13]
        mem_r.wdata <= rr_val;
      end
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Later writes win: port, then op,
  // then pointer update, then load data.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        gpr_r[i] <= GPR_RESET;
      end
    end else begin
      if (i_reg_we && (i_reg_addr <= REGFILE_LAST)) begin
        gpr_r[i_reg_addr[REG_IDX_W-1:0]] <= i_reg_wdata;
      end
      if (take) begin
        case (i_cmd.op)
          op_rotate_right_carry,
          op_arith_shift_right,
          op_nibble_swap:       gpr_r[i_cmd.rd] <= shift_res;     // [RQ1] [RQ2] [RQ12]
          op_t_flag_to_reg_bit: begin
            gpr_r[i_cmd.rd][i_cmd.bit_sel] <= flags_r[FLAG_T];    // [RQ4]
          end
          op_reg_copy:          gpr_r[i_cmd.rd] <= rr_val;        // [RQ12]
          op_reg_pair_copy: begin
            gpr_r[{i_cmd.rd[REG_IDX_W-1:1], 1'b0}] <= gpr_r[{i_cmd.rr[REG_IDX_W-1:1], 1'b0}];
            gpr_r[{i_cmd.rd[REG_IDX_W-1:1], 1'b1}] <= gpr_r[{i_cmd.rr[REG_IDX_W-1:1], 1'b1}];
          end
          op_immediate_load:    gpr_r[i_cmd.rd] <= i_cmd.imm;     // [RQ12]
          default: ;
        endcase
        if (is_mem_op && ptr_upd) begin
          gpr_r[ptr_lo]                 <= ptr_next[DATA_W-1:0];  // [RQ7] [RQ8] [RQ10] [RQ11]
          gpr_r[ptr_lo + REG_IDX_W'(1)] <= ptr_next[ADDR_W-1:DATA_W];
        end
      end
      if (load_pend_r) begin
        gpr_r[load_rd_r] <= i_mem_rdata;               // [RQ6] [RQ7] [RQ8] [RQ9] [RQ13]
      end
    end
  end

  // ****************************************************************
  // Flag register
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flags_r <= FLAG_RESET;
    end else begin
      if (i_reg_we && (i_reg_addr == FLAG_REG_ADDR)) begin
        flags_r <= i_reg_wdata;
      end
      if (take) begin
        if ((i_cmd.op == op_rotate_right_carry) || (i_cmd.op == op_arith_shift_right)) begin
          flags_r[FLAG_C] <= sh_c;                     // [RQ1] [RQ2]
          flags_r[FLAG_Z] <= sh_z;
          flags_r[FLAG_N] <= sh_n;
          flags_r[FLAG_V] <= sh_v;
        end
        if (i_cmd.op == op_reg_bit_to_t_flag) begin
          flags_r[FLAG_T] <= rr_val[i_cmd.bit_sel];    // [RQ3]
        end
        if (fix_flag) begin
          flags_r[fix_idx] <= fix_val;                 // [RQ5] [RQ12]
        end
      end
    end
  end

  // ****************************************************************
  // Register port read
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      reg_rdata_r <= '0;
    end else if (i_reg_re) begin
      if (i_reg_addr <= REGFILE_LAST) begin
        reg_rdata_r <= gpr_r[i_reg_addr[REG_IDX_W-1:0]];
      end else if (i_reg_addr == FLAG_REG_ADDR) begin
        reg_rdata_r <= flags_r;
      end else begin
        reg_rdata_r <= '0;
      end
    end else begin
      reg_rdata_r <= '0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic ready_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= !(take && is_mem_op);
    end
  end

  assign o_ready     = ready_r;
  assign o_done      = done_r;
  assign o_mem       = mem_r;
  assign o_flags     = flags_r;
  assign o_reg_rdata = reg_rdata_r;

endmodule

// file: verif/bitop_load_store_exec_sva.sv
// Port-level assertions for the executor.
`timescale 1ns/1ps
module bitop_load_store_exec_sva
  import bitop_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  input  wire logic                i_cmd_valid,
  input  wire bitop_pkg::cmd_t     i_cmd,
  input  wire logic                o_ready,
  input  wire logic                o_done,
  input  wire bitop_pkg::mem_req_t o_mem,
  input  wire logic [DATA_W-1:0]   o_flags,
  input  wire logic                i_reg_we
);
  localparam int DED_MAP [8] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T, FLAG_H};
  logic              take, ded, mem_op, ld, st, quiet;
  logic [5:0]        rel;
  logic [DATA_W-1:0] ded_flags;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Edges with a port write are left out; it may touch flags.
  assign take   = i_cmd_valid && o_ready && !i_reg_we;
  assign rel    = i_cmd.op - 6'h08;
  assign ded    = rel < 6'h10;
  assign st     = i_cmd.op == op_indirect_write;
  assign ld     = i_cmd.op inside {op_indirect_load, op_displaced_load, op_direct_load};
  assign mem_op = ld || st;
  assign quiet  = mem_op || i_cmd.op inside {op_t_flag_to_reg_bit, op_reg_copy,
                                             op_reg_pair_copy, op_immediate_load, op_nibble_swap};
  always_comb begin
    ded_flags = o_flags;
    ded_flags[DED_MAP[rel[3:1]]] = !rel[0];
  end
  sequence mem_hold;
    !o_ready && !o_done ##1 o_ready && o_done;
  endsequence
  sequence strobe_once(s);
    s ##1 !s;
  endsequence
  single_done_a: assert property (take && !mem_op |=> o_done)
    else $error("no done after one-cycle op");
  mem_two_a: assert property (take && mem_op |=> mem_hold)
    else $error("memory op not two cycles");
  load_read_a: assert property (take && ld |=> strobe_once(o_mem.re && !o_mem.we))
    else $error("bad read strobe");
  store_write_a: assert property (take && st |=> strobe_once(o_mem.we && !o_mem.re))
    else $error("bad write strobe");
  direct_addr_a: assert property (
    take && i_cmd.op == op_direct_load |=> o_mem.addr == $past(i_cmd.addr))
    else $error("bad direct address");
  flag_force_a: assert property (take && ded |=> o_flags == $past(ded_flags))
    else $error("bad flag force");
  index_flag_a: assert property (
    take && i_cmd.op == op_indexed_flag_set
    |=> o_flags == ($past(o_flags) | (8'h01 << $past(i_cmd.bit_sel))))
    else $error("bad indexed flag set");
  t_only_a: assert property (
    take && i_cmd.op == op_reg_bit_to_t_flag |=> ((o_flags ^ $past(o_flags)) & 8'hbf) == 8'h00)
    else $error("bit to T touched other flags");
  flags_kept_a: assert property (take && quiet |=> $stable(o_flags))
    else $error("flagless op changed flags");
  shift_flags_a: assert property (
    take && i_cmd.op inside {op_rotate_right_carry, op_arith_shift_right}
    |=> o_flags[7:4] == $past(o_flags[7:4]) && o_flags[FLAG_V] == (o_flags[FLAG_N] ^ o_flags[FLAG_C]))
    else $error("shift flags inconsistent");
endmodule

// file: verif/data_mem_model.sv
// Behavioural data memory for the executor.
`timescale 1ns/1ps
module data_mem_model
  import bitop_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire bitop_pkg::mem_req_t   i_mem,
  output logic      [DATA_W-1:0]     o_rdata
);
  logic [DATA_W-1:0] mem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
    end
  end
  // Inverted data outside a read catch a late sample.
  assign o_rdata = i_mem.re ? mem[i_mem.addr[7:0]] : ~mem[i_mem.addr[7:0]];
  always @(posedge i_clk) begin
    if (i_mem.we) begin
      mem[i_mem.addr[7:0]] <= i_mem.wdata;
    end
  end
endmodule

// file: verif/bitop_load_store_exec_test.sv
// Self-checking bench for the load/store executor.
`timescale 1ns/1ps
module bitop_load_store_exec_test;
  import bitop_pkg::*;
  logic              i_clk, i_sys_rst, i_cmd_valid, o_ready, o_done, i_reg_we, i_reg_re;
  cmd_t              i_cmd;
  mem_req_t          o_mem;
  logic [DATA_W-1:0] i_mem_rdata, o_flags, i_reg_wdata, o_reg_rdata, fl, v, r;
  logic [5:0]        i_reg_addr;
  int                fail_count, comparisons, cycles;
  int                fmap [8] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V, FLAG_T, FLAG_H};
  logic [7:0]        sv [6] = '{8'h81, 8'h40, 8'h01, 8'h80, 8'h7e, 8'hfe};

  bitop_load_store_exec bitop_load_store_exec_inst (.i_clk, .i_sys_rst, .i_cmd_valid, .i_cmd,
    .o_ready, .o_done, .o_mem, .i_mem_rdata, .o_flags, .i_reg_addr, .i_reg_wdata, .i_reg_we,
    .i_reg_re, .o_reg_rdata);
  data_mem_model data_mem_model_inst (.i_clk, .i_mem(o_mem), .o_rdata(i_mem_rdata));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic reg_wr(logic [5:0] a, logic [7:0] d);
    i_reg_we    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_we <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd_chk(string n, logic [5:0] a, logic [7:0] e);
    i_reg_re   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_re <= 1'b0;
    @(posedge i_clk);
    check(n, o_reg_rdata, e);
  endtask
  function automatic cmd_t mk(op_t o, logic [4:0] d = 5'h00, logic [4:0] s = 5'h00,
                              logic [7:0] k = 8'h00, ptr_sel_t p = ptr_x, amode_t am = am_plain,
                              logic [15:0] a = 16'h0000);
    return '{o, d, s, k[2:0], k, p, am, k[5:0], a};
  endfunction
  task automatic run(cmd_t c, int cyc, logic [15:0] ea = 16'h0000, logic [1:0] ews = 2'b00,
                     logic [7:0] ewd = 8'h00);
    int       n;
    mem_req_t m;
    i_cmd_valid <= 1'b1;
    i_cmd       <= c;
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      if (n == 1) m = o_mem;
    end while (o_done !== 1'b1 && n < 4);
    check("done_cyc", n, cyc);
    if (cyc == 2) begin
      check("mem_addr", m.addr, ea);
      check("mem_stb", {m.we, m.re}, ews);
      if (ews == 2'b10) check("mem_wdata", m.wdata, ewd);
    end
  endtask
  task automatic mem_op(op_t o, logic [4:0] g, ptr_sel_t p, amode_t am, logic [15:0] ea,
                        logic [7:0] ewd = 8'h00, logic [7:0] k = 8'h00, logic [15:0] a = 16'h0000);
    run(mk(o, g, g, k, p, am, a), 2, ea, (o == op_indirect_write) ? 2'b10 : 2'b01, ewd);
  endtask
  task automatic set_ptr(logic [4:0] lo, logic [15:0] val);
    reg_wr({1'b0, lo}, val[7:0]);
    reg_wr({1'b0, lo} + 6'h01, val[15:8]);
  endtask
  task automatic ptr_chk(logic [4:0] lo, logic [15:0] val);
    rd_chk("ptr_lo", {1'b0, lo}, val[7:0]);
    rd_chk("ptr_hi", {1'b0, lo} + 6'h01, val[15:8]);
  endtask

  initial begin
    i_sys_rst   = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd       = '0;
    i_reg_we    = 1'b0;
    i_reg_re    = 1'b0;
    i_reg_addr  = 6'h00;
    i_reg_wdata = 8'h00;
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rd_chk("gpr_reset", 6'h05, GPR_RESET);
    rd_chk("flag_reset", FLAG_REG_ADDR, FLAG_RESET);
    reg_wr(6'h20, 8'hff);
    rd_chk("unmapped", 6'h20, 8'h00);
    fl = 8'h00;
    for (int i = 0; i < 16; i++) begin
      fl[fmap[i % 8]] = (i < 8);
      run(mk(op_t'(6'h08 + 2 * (i % 8) + i / 8)), 1);
      check("flag_force", o_flags, fl);
      fl[i % 8] = (i < 8);
      run(mk(i < 8 ? op_indexed_flag_set : op_indexed_flag_clear, 5'h00, 5'h00, 8'(i)), 1);
      check("idx_flag", o_flags, fl);
    end
    for (int i = 0; i < 12; i++) begin
      v = sv[i % 6];
      reg_wr(6'h01, v);
      run(mk(i[0] ? op_carry_set_op : op_carry_clear_op), 1);
      r = (i < 6) ? {i[0], v[7:1]} : {v[7], v[7:1]};
      fl[FLAG_C] = v[0];
      fl[FLAG_Z] = (r == 8'h00);
      fl[FLAG_N] = r[7];
      fl[FLAG_V] = r[7] ^ v[0];
      run(mk(i < 6 ? op_rotate_right_carry : op_arith_shift_right, 5'h01), 1);
      rd_chk("shift_res", 6'h01, r);
      check("shift_flags", o_flags, fl);
    end
    reg_wr(6'h03, 8'h10);
    fl[FLAG_T] = 1'b1;
    run(mk(op_reg_bit_to_t_flag, 5'h00, 5'h03, 8'h04), 1);
    check("bit_to_t", o_flags, fl);
    run(mk(op_t_flag_to_reg_bit, 5'h04, 5'h00, 8'h02), 1);
    rd_chk("t_to_bit", 6'h04, 8'h04);
    fl[FLAG_T] = 1'b0;
    run(mk(op_reg_bit_to_t_flag, 5'h00, 5'h03, 8'h03), 1);
    check("bit_to_t_zero", o_flags, fl);
    run(mk(op_immediate_load, 5'h10, 5'h00, 8'ha5), 1);
    run(mk(op_nibble_swap, 5'h10), 1);
    run(mk(op_immediate_load, 5'h11, 5'h00, 8'h3c), 1);
    run(mk(op_reg_pair_copy, 5'h12, 5'h10), 1);
    run(mk(op_reg_copy, 5'h14, 5'h11), 1);
    rd_chk("swap", 6'h10, 8'h5a);
    rd_chk("pair_lo", 6'h12, 8'h5a);
    rd_chk("pair_hi", 6'h13, 8'h3c);
    rd_chk("copy", 6'h14, 8'h3c);
    check("move_flags", o_flags, fl);
    set_ptr(PTR_X_LO, 16'h00ff);
    set_ptr(PTR_Y_LO, 16'h0020);
    set_ptr(PTR_Z_LO, 16'h0030);
    mem_op(op_indirect_load, 5'h00, ptr_x, am_plain, 16'h00ff);
    ptr_chk(PTR_X_LO, 16'h00ff);
    mem_op(op_indirect_load, 5'h01, ptr_x, am_post_inc, 16'h00ff);
    ptr_chk(PTR_X_LO, 16'h0100);
    mem_op(op_indirect_write, 5'h10, ptr_x, am_pre_dec, 16'h00ff, 8'h5a);
    ptr_chk(PTR_X_LO, 16'h00ff);
    mem_op(op_indirect_write, 5'h11, ptr_x, am_post_inc, 16'h00ff, 8'h3c);
    ptr_chk(PTR_X_LO, 16'h0100);
    mem_op(op_indirect_load, 5'h05, ptr_x, am_pre_dec, 16'h00ff);
    ptr_chk(PTR_X_LO, 16'h00ff);
    rd_chk("ld_plain", 6'h00, 8'hc3);
    rd_chk("ld_post", 6'h01, 8'hc3);
    rd_chk("ld_back", 6'h05, 8'h3c);
    mem_op(op_indirect_load, 5'h02, ptr_y, am_pre_dec, 16'h001f);
    ptr_chk(PTR_Y_LO, 16'h001f);
    rd_chk("ld_pre_y", 6'h02, 8'h23);
    mem_op(op_displaced_load, 5'h03, ptr_z, am_disp, 16'h006f, 8'h00, 8'h3f);
    ptr_chk(PTR_Z_LO, 16'h0030);
    rd_chk("ld_disp", 6'h03, 8'h53);
    mem_op(op_direct_load, 5'h04, ptr_x, am_plain, 16'h00c7, 8'h00, 8'h00, 16'h00c7);
    rd_chk("ld_direct", 6'h04, 8'hfb);
    check("mem_flags", o_flags, fl);
    tally_and_finish();
  end
endmodule

bind bitop_load_store_exec bitop_load_store_exec_sva bitop_load_store_exec_sva_inst (.i_clk,
  .i_sys_rst, .i_cmd_valid, .i_cmd, .o_ready, .o_done, .o_mem, .o_flags, .i_reg_we);
